/* File: pkg/emtim_pkg.sv */
// package: constants and types for the external memory bus sequencer
package emtim_pkg;

  // ----------------------------------------------------------------
  // configuration field layout (ext_mem_config_reg)
  // ----------------------------------------------------------------
  localparam int unsigned CFG_MODE_LSB  = 2;
  localparam int unsigned CFG_MODE_MSB  = 4;
  localparam int unsigned CFG_MUXN_BIT  = 4;
  localparam int unsigned CFG_ALE_LSB   = 0;
  localparam logic [1:0]  MAP_ONCHIP    = 2'h0;
  localparam logic [1:0]  MAP_SPLIT     = 2'h1;
  localparam logic [1:0]  MAP_BANK      = 2'h2;
  localparam logic [1:0]  MAP_EXTONLY   = 2'h3;
  localparam logic [7:0]  CFG_RESET     = 8'h03;

  // ----------------------------------------------------------------
  // timing field layout (ext_mem_timing_reg)
  // ----------------------------------------------------------------
  localparam int unsigned TIM_SETUP_LSB = 6;
  localparam int unsigned TIM_WIDTH_LSB = 2;
  localparam int unsigned TIM_HOLD_LSB  = 0;
  localparam logic [7:0]  TIM_RESET     = 8'hFF;

  // ----------------------------------------------------------------
  // clock period, move overhead, bus widths and buffer depth
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MOVE_OVERHEAD = 4;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 8;

  typedef enum logic [2:0] {
    EMTIM_IDLE,
    EMTIM_ALE_HI,
    EMTIM_ALE_LO,
    EMTIM_SETUP,
    EMTIM_STROBE,
    EMTIM_HOLD,
    EMTIM_DONE
  } emtim_state_t;

endpackage : emtim_pkg

/* File: rtl/emtim_fifo.sv */
// FIFO: parameterised width and depth, valid/ready on both sides
`timescale 1ns/1ps
module emtim_fifo
  import emtim_pkg::*;
#(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } emtim_fifo_t;

  emtim_fifo_t      st_reg;
  emtim_fifo_t      st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_reg.rd_ptr];

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_next.count = st_reg.count + 1'b1;
      2'b01:   st_next.count = st_reg.count - 1'b1;
      default: st_next.count = st_reg.count;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage needs no reset; only entries counted in are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end
endmodule : emtim_fifo

/* File: rtl/emtim_rst_sync.sv */
// reset release synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ps
module emtim_rst_sync (
  input  wire logic clk,
  input  wire logic rst_in_n,
  output logic      rst_out_n
);
  logic [1:0] sync_reg;

  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], 1'b1};
    end
  end

  assign rst_out_n = sync_reg[1];
endmodule : emtim_rst_sync

/* File: rtl/emtim_top.sv */
// external memory bus sequencer: request FIFO, cycle state machine, pin drive
//
// Behaviour
// R1: 16-bit moves non-multiplexed for modes 101, 110, 111
// R2: 8-bit non-muxed, no bank, modes 101, 111
// R3: 8-bit non-muxed with bank byte, mode 110
// R4: 16-bit moves multiplexed with latch, modes 001-011
// R5: 8-bit muxed, no bank, modes 001, 011
// R6: 8-bit muxed with bank byte, mode 010
// R7: setup before strobe, zero to three periods
// R8: strobe width one to sixteen periods
// R9: hold after strobe, zero to three periods
// R10: latch high then low, one to four each
// R11: write data set up before strobe end
// R12: write data held through programmed hold time
// R13: routed to lower or upper ports, moves only
// R14: move lasts timing settings plus four cycles
// R15: setup and hold reset to maximum
// R16: bank mode drives all sixteen address lines
// R17: no bank: upper address lines left undriven
// R18: on-chip-only mapping makes no external cycles
// R19: read data sampled at strobe end; CPU stalled
`timescale 1ns/1ps
module emtim_top
  import emtim_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          ext_mem_config_reg,
  input  wire logic [7:0]          ext_mem_timing_reg,
  input  wire logic [7:0]          ext_mem_bank_reg,
  input  wire logic                port_upper_sel,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic                req_write,
  input  wire logic                req_wide,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0]   req_wdata,
  output logic                     cpu_stall,
  output logic                     rd_valid,
  output logic      [DATA_W-1:0]   rd_data,
  output logic                     busy,
  output logic      [7:0]          lo_addr_out,
  output logic      [7:0]          lo_addr_oe,
  output logic      [7:0]          lo_hi_out,
  output logic      [7:0]          lo_hi_oe,
  output logic      [7:0]          lo_data_out,
  output logic      [7:0]          lo_data_oe,
  input  wire logic [7:0]          lo_data_in,
  output logic                     lo_rd_n,
  output logic                     lo_wr_n,
  output logic                     lo_ale,
  output logic      [7:0]          up_addr_out,
  output logic      [7:0]          up_addr_oe,
  output logic      [7:0]          up_hi_out,
  output logic      [7:0]          up_hi_oe,
  output logic      [7:0]          up_data_out,
  output logic      [7:0]          up_data_oe,
  input  wire logic [7:0]          up_data_in,
  output logic                     up_rd_n,
  output logic                     up_wr_n,
  output logic                     up_ale
);
  localparam int unsigned REQ_W = 2 + ADDR_W + DATA_W;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_sync_n;

  emtim_rst_sync u_rst (
    .clk       (core_clk),
    .rst_in_n  (rst_n),
    .rst_out_n (rst_sync_n)
  );

  // ----------------------------------------------------------------
  // request buffer
  // ----------------------------------------------------------------
  logic              q_valid;
  logic              q_ready;
  logic [REQ_W-1:0]  q_data;

  emtim_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_sync_n),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_wide, req_addr, req_wdata}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    emtim_state_t      state;
    logic [3:0]        cnt;
    logic              write;
    logic              muxed;
    logic              drive_hi;
    logic              upper;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        setup;
    logic [3:0]        width;
    logic [1:0]        hold;
    logic [1:0]        ale_w;
    logic              rd_n;
    logic              wr_n;
    logic              ale;
    logic              addr_oe;
    logic              data_oe;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } emtim_top_t;

  emtim_top_t st_reg;
  emtim_top_t st_next;

  logic [2:0]        mode;
  logic [1:0]        map_sel;
  logic              q_write;
  logic              q_wide;
  logic [ADDR_W-1:0] q_addr;
  logic [DATA_W-1:0] q_wdata;
  logic [7:0]        data_in;

  assign mode    = ext_mem_config_reg[CFG_MODE_MSB:CFG_MODE_LSB];
  assign map_sel = ext_mem_config_reg[CFG_MODE_LSB+1:CFG_MODE_LSB];
  assign {q_write, q_wide, q_addr, q_wdata} = q_data;
  assign data_in = st_reg.upper ? up_data_in : lo_data_in;

  // takes one request per sequence; the buffer holds back the CPU meanwhile
  assign q_ready = (st_reg.state == EMTIM_IDLE); // R19

  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    case (st_reg.state)
      EMTIM_IDLE: begin
        if (q_valid) begin
          if (map_sel == MAP_ONCHIP) begin
            // no external cycle at all; request is consumed and dropped
            st_next.state = EMTIM_IDLE; // R18
          end else begin
            st_next.write    = q_write;
            st_next.muxed    = !mode[CFG_MUXN_BIT-CFG_MODE_LSB]; // R1 R4
            // wide moves and bank mode drive the high byte; else it is left undriven
            st_next.drive_hi = q_wide || (map_sel == MAP_BANK); // R2 R3 R5 R6 R16 R17
            st_next.addr     = q_wide ? q_addr
                             : (map_sel == MAP_BANK) ? {ext_mem_bank_reg, q_addr[7:0]} // R3 R6 R16
                             : {8'h00, q_addr[7:0]}; // R17
            st_next.wdata    = q_wdata;
            st_next.upper    = port_upper_sel; // R13
            st_next.setup    = ext_mem_timing_reg[TIM_SETUP_LSB+1:TIM_SETUP_LSB];
            st_next.width    = ext_mem_timing_reg[TIM_WIDTH_LSB+3:TIM_WIDTH_LSB];
            st_next.hold     = ext_mem_timing_reg[TIM_HOLD_LSB+1:TIM_HOLD_LSB];
            st_next.ale_w    = ext_mem_config_reg[CFG_ALE_LSB+1:CFG_ALE_LSB];
            st_next.addr_oe  = 1'b1;
            st_next.cnt      = 4'h0;
            if (!mode[CFG_MUXN_BIT-CFG_MODE_LSB]) begin
              st_next.state = EMTIM_ALE_HI;
              st_next.ale   = 1'b1; // R10
            end else begin
              st_next.state = EMTIM_SETUP;
              st_next.data_oe = q_write; // R11
            end
          end
        end
      end
      EMTIM_ALE_HI: begin
        if (st_reg.cnt == {2'h0, st_reg.ale_w}) begin
          st_next.state = EMTIM_ALE_LO;
          st_next.ale   = 1'b0; // R10
          st_next.cnt   = 4'h0;
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
      EMTIM_ALE_LO: begin
        if (st_reg.cnt == {2'h0, st_reg.ale_w}) begin
          st_next.state   = EMTIM_SETUP;
          st_next.cnt     = 4'h0;
          st_next.data_oe = st_reg.write; // R11
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
      EMTIM_SETUP: begin
        // one fixed cycle plus the programmed setup count
        if (st_reg.cnt == {2'h0, st_reg.setup}) begin
          st_next.state = EMTIM_STROBE;
          st_next.cnt   = 4'h0;
          st_next.rd_n  = st_reg.write; // R7
          st_next.wr_n  = !st_reg.write; // R7
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
      EMTIM_STROBE: begin
        if (st_reg.cnt == st_reg.width) begin
          st_next.state = EMTIM_HOLD;
          st_next.cnt   = 4'h0;
          st_next.rd_n  = 1'b1; // R8
          st_next.wr_n  = 1'b1; // R8
          if (!st_reg.write) begin
            st_next.rdata = data_in; // R19
          end
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
      EMTIM_HOLD: begin
        // data and address stay driven through the hold count
        if (st_reg.cnt == {2'h0, st_reg.hold}) begin
          st_next.state   = EMTIM_DONE; // R9 R12
          st_next.addr_oe = 1'b0;
          st_next.data_oe = 1'b0;
          st_next.cnt     = 4'h0;
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
      EMTIM_DONE: begin
        // two closing cycles; with the extra setup and hold cycles they make up the fixed overhead of a move
        if (st_reg.cnt == 4'(MOVE_OVERHEAD - 3)) begin
          st_next.state  = EMTIM_IDLE; // R14
          st_next.rvalid = !st_reg.write;
          st_next.cnt    = 4'h0;
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
      default: begin
        st_next.state = EMTIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg       <= '0;
      st_reg.state <= EMTIM_IDLE;
      st_reg.setup <= TIM_RESET[TIM_SETUP_LSB+1:TIM_SETUP_LSB]; // R15
      st_reg.width <= TIM_RESET[TIM_WIDTH_LSB+3:TIM_WIDTH_LSB];
      st_reg.hold  <= TIM_RESET[TIM_HOLD_LSB+1:TIM_HOLD_LSB]; // R15
      st_reg.rd_n  <= 1'b1;
      st_reg.wr_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drive: one port group active, the other idle
  // ----------------------------------------------------------------
  logic [7:0] low_byte;
  logic [7:0] lo_oe8;
  logic [7:0] hi_oe8;
  logic [7:0] dat_oe8;

  // muxed mode: low address shares the data lines through both latch phases, EMTIM_ALE_HI and EMTIM_ALE_LO
  assign low_byte = (st_reg.muxed && (st_reg.state == EMTIM_ALE_HI || st_reg.state == EMTIM_ALE_LO))
                    ? st_reg.addr[7:0] : st_reg.wdata; // R4
  assign lo_oe8   = {8{st_reg.addr_oe && !st_reg.muxed}}; // R1 R2
  assign hi_oe8   = {8{st_reg.addr_oe && st_reg.drive_hi}}; // R16 R17
  assign dat_oe8  = {8{st_reg.data_oe || (st_reg.muxed && st_reg.addr_oe
                    && (st_reg.state == EMTIM_ALE_HI || st_reg.state == EMTIM_ALE_LO))}}; // R12

  assign lo_addr_out = st_reg.addr[7:0];
  assign lo_addr_oe  = st_reg.upper ? 8'h00 : lo_oe8;
  assign lo_hi_out   = st_reg.addr[15:8];
  assign lo_hi_oe    = st_reg.upper ? 8'h00 : hi_oe8;
  assign lo_data_out = low_byte;
  assign lo_data_oe  = st_reg.upper ? 8'h00 : dat_oe8;
  assign lo_rd_n     = st_reg.upper ? 1'b1 : st_reg.rd_n; // R13
  assign lo_wr_n     = st_reg.upper ? 1'b1 : st_reg.wr_n;
  assign lo_ale      = st_reg.upper ? 1'b0 : st_reg.ale;
  assign up_addr_out = st_reg.addr[7:0];
  assign up_addr_oe  = st_reg.upper ? lo_oe8 : 8'h00;
  assign up_hi_out   = st_reg.addr[15:8];
  assign up_hi_oe    = st_reg.upper ? hi_oe8 : 8'h00;
  assign up_data_out = low_byte;
  assign up_data_oe  = st_reg.upper ? dat_oe8 : 8'h00;
  assign up_rd_n     = st_reg.upper ? st_reg.rd_n : 1'b1; // R13
  assign up_wr_n     = st_reg.upper ? st_reg.wr_n : 1'b1;
  assign up_ale      = st_reg.upper ? st_reg.ale : 1'b0;

  // ----------------------------------------------------------------
  // CPU side
  // ----------------------------------------------------------------
  assign busy      = (st_reg.state != EMTIM_IDLE);
  assign cpu_stall = busy || q_valid; // R19
  assign rd_valid  = st_reg.rvalid;
  assign rd_data   = st_reg.rdata;
endmodule : emtim_top

/* File: testbench/emtim_sram_model.sv */
// behavioural asynchronous memory hung on one pin group of the sequencer
`timescale 1ns/1ps
module emtim_sram_model #(
  parameter int unsigned RD_DLY = 5
) (
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       ale,
  input  wire logic [7:0] addr_out,
  input  wire logic [7:0] addr_oe,
  input  wire logic [7:0] hi_out,
  input  wire logic [7:0] hi_oe,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  output logic      [7:0] data_in
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_reg = 8'hFF;
  logic        dv      = 1'b0;
  logic [15:0] addr;
  // upper address lines nobody drives float high through the port pull-ups; undriven low lines take the latch value
  assign addr = {hi_oe[0] ? hi_out : 8'hFF, addr_oe[0] ? addr_out : lat_reg};
  always @(negedge ale) lat_reg = data_out;
  always @(negedge rd_n) begin
    dv = 1'b0;
    #(RD_DLY) dv = 1'b1;
  end
  always @(posedge wr_n) if (data_oe[0]) mem[addr] = data_out;
  // data shows only after the access time, so an early sample still sees the pull-up level
  always @* data_in = (!rd_n && dv) ? mem[addr] : 8'hFF;
endmodule : emtim_sram_model

/* File: testbench/emtim_assertions.sv */
// pin-level assertions for the external memory sequencer
`timescale 1ns/1ps
module emtim_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] ext_mem_config_reg,
  input wire logic [7:0] ext_mem_timing_reg,
  input wire logic       port_upper_sel,
  input wire logic       busy,
  input wire logic       cpu_stall,
  input wire logic       rd_valid,
  input wire logic       lo_rd_n,
  input wire logic       lo_wr_n,
  input wire logic       lo_ale,
  input wire logic [7:0] lo_hi_oe,
  input wire logic [7:0] lo_data_oe,
  input wire logic       up_rd_n,
  input wire logic       up_wr_n,
  input wire logic       up_ale
);
  logic       stb;
  logic [4:0] stb_cnt_reg;
  logic [2:0] ale_cnt_reg;
  assign stb = lo_rd_n & lo_wr_n;
  // low-strobe and high-latch run lengths, cleared by the opposite level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_cnt_reg <= 5'h0;
      ale_cnt_reg <= 3'h0;
    end else begin
      stb_cnt_reg <= stb ? 5'h0 : stb_cnt_reg + 5'h1;
      ale_cnt_reg <= lo_ale ? ale_cnt_reg + 3'h1 : 3'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  idle_quiet_a: assert property (!busy |-> stb && up_rd_n && up_wr_n)
    else $error("strobe low while idle");
  route_sel_a: assert property (!port_upper_sel && busy |-> up_rd_n && up_wr_n && !up_ale)
    else $error("upper group moved while lower selected");
  strobe_len_a: assert property ($rose(stb) |-> stb_cnt_reg == {1'b0, ext_mem_timing_reg[5:2]} + 5'h1)
    else $error("strobe width wrong");
  latch_len_a: assert property ($fell(lo_ale) |-> ale_cnt_reg == {1'b0, ext_mem_config_reg[1:0]} + 3'h1)
    else $error("latch width wrong");
  nomux_latch_a: assert property (ext_mem_config_reg[4] |-> !lo_ale && !up_ale)
    else $error("latch pulse in non-multiplexed mode");
  onchip_still_a: assert property (ext_mem_config_reg[3:2] == 2'h0 |-> stb && !lo_ale)
    else $error("bus cycle in on-chip mapping");
  wdata_setup_a: assert property ($rose(lo_wr_n) |-> $past(lo_data_oe) == 8'hFF)
    else $error("write data not driven before strobe end");
  wdata_hold_a: assert property ($rose(lo_wr_n) |-> lo_data_oe == 8'hFF)
    else $error("write data released with strobe");
  stall_busy_a: assert property (busy |-> cpu_stall)
    else $error("cpu not stalled during move");
  read_answer_a: assert property ($rose(lo_rd_n) |-> ##[0:12] rd_valid)
    else $error("no read answer");
  bank_drive_a: assert property (ext_mem_config_reg[3:2] == 2'h2 && !stb |-> lo_hi_oe == 8'hFF)
    else $error("upper address not driven in bank mode");
  cover property ($fell(lo_ale));
  cover property (rd_valid);
  cover property (!up_wr_n);
endmodule : emtim_checker

bind emtim_top emtim_checker u_emtim_checker (
  .core_clk, .rst_n, .ext_mem_config_reg, .ext_mem_timing_reg, .port_upper_sel, .busy, .cpu_stall,
  .rd_valid, .lo_rd_n, .lo_wr_n, .lo_ale, .lo_hi_oe, .lo_data_oe, .up_rd_n, .up_wr_n, .up_ale);

/* File: testbench/testbench.sv */
// self-checking bench: sequencer, one memory on each pin group, scenario tasks
`timescale 1ns/1ps
module testbench;
  import emtim_pkg::*;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
  logic        core_clk, rst_n, port_upper_sel, req_valid, req_write, req_wide, full_seen;
  logic [7:0]  ext_mem_config_reg, ext_mem_timing_reg, ext_mem_bank_reg, req_wdata, rd_last, rd_data;
  logic [15:0] req_addr;
  logic        req_ready, cpu_stall, rd_valid, busy, lo_rd_n, lo_wr_n, lo_ale, up_rd_n, up_wr_n, up_ale;
  logic [7:0]  lo_addr_out, lo_addr_oe, lo_hi_out, lo_hi_oe, lo_data_out, lo_data_oe, lo_data_in;
  logic [7:0]  up_addr_out, up_addr_oe, up_hi_out, up_hi_oe, up_data_out, up_data_oe, up_data_in;
  int          bad_count, compares, rd_cnt;

  emtim_top #(.DEPTH(FIFO_DEPTH)) u_emtim_top (
    .core_clk, .rst_n, .ext_mem_config_reg, .ext_mem_timing_reg, .ext_mem_bank_reg, .port_upper_sel,
    .req_valid, .req_ready, .req_write, .req_wide, .req_addr, .req_wdata, .cpu_stall, .rd_valid, .rd_data,
    .busy, .lo_addr_out, .lo_addr_oe, .lo_hi_out, .lo_hi_oe, .lo_data_out, .lo_data_oe, .lo_data_in,
    .lo_rd_n, .lo_wr_n, .lo_ale, .up_addr_out, .up_addr_oe, .up_hi_out, .up_hi_oe, .up_data_out,
    .up_data_oe, .up_data_in, .up_rd_n, .up_wr_n, .up_ale);
  emtim_sram_model #(.RD_DLY(5)) u_emtim_sram_model (.rd_n(lo_rd_n), .wr_n(lo_wr_n), .ale(lo_ale),
    .addr_out(lo_addr_out), .addr_oe(lo_addr_oe), .hi_out(lo_hi_out), .hi_oe(lo_hi_oe),
    .data_out(lo_data_out), .data_oe(lo_data_oe), .data_in(lo_data_in));
  // slow part on the upper group: data only 40 ns after the strobe falls
  emtim_sram_model #(.RD_DLY(40)) u_emtim_sram_model_up (.rd_n(up_rd_n), .wr_n(up_wr_n), .ale(up_ale),
    .addr_out(up_addr_out), .addr_oe(up_addr_oe), .hi_out(up_hi_out), .hi_oe(up_hi_oe),
    .data_out(up_data_out), .data_oe(up_data_oe), .data_in(up_data_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (rd_valid === 1'b1) begin
    rd_cnt  <= rd_cnt + 1;
    rd_last <= rd_data;
  end

  function automatic int exp_cyc();
    exp_cyc = ext_mem_timing_reg[7:6] + ext_mem_timing_reg[5:2] + 1 + ext_mem_timing_reg[1:0] + MOVE_OVERHEAD;
    if (!ext_mem_config_reg[4]) exp_cyc += 2 * (ext_mem_config_reg[1:0] + 1);
  endfunction : exp_cyc

  // request stays up until the falling edge after the accepting edge
  task automatic push(input logic w, wd, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = w;
    req_wide  = wd;
    req_addr  = a;
    req_wdata = d;
    k = 0;
    while (req_ready !== 1'b1 && k < 400) begin
      full_seen = 1'b1;
      @(negedge core_clk);
      k++;
    end
    if (k >= 400) bad_count++;
  endtask : push

  task automatic mv(input logic w, wd, input logic [15:0] a, input logic [7:0] d);
    int k;
    int n;
    push(w, wd, a, d);
    @(negedge core_clk);
    req_valid = 1'b0;
    k = 0;
    n = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    while (busy === 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    if (k >= 20 || n >= 300) bad_count++;
    repeat (2) @(negedge core_clk);
    `CHK("move cycles", exp_cyc(), n)
    if (!w) `CHK("read data", d, rd_last)
  endtask : mv

  task automatic t_modes();
    logic [2:0]  m;
    logic [15:0] key;
    for (int i = 0; i < 6; i++) begin
      m = (i < 3) ? 3'(i + 1) : 3'(i + 2);
      ext_mem_config_reg = {3'h0, m, 2'(i)};
      ext_mem_timing_reg = {2'(i), 4'(i * 3), 2'(i + 1)};
      key = {(m[1:0] == MAP_BANK) ? ext_mem_bank_reg : 8'hFF, 8'(8'h30 + i)};
      mv(1'b1, 1'b0, {8'h77, key[7:0]}, 8'(8'h10 + i));
      mv(1'b0, 1'b1, key, 8'(8'h10 + i));
      mv(1'b1, 1'b1, 16'(16'hC400 + i), 8'(8'hE0 + i));
      mv(1'b0, 1'b1, 16'(16'hC400 + i), 8'(8'hE0 + i));
    end
  endtask : t_modes

  task automatic t_onchip();
    int c;
    for (int j = 0; j < 2; j++) begin
      ext_mem_config_reg = {3'h0, j[0], 4'h0};
      c = rd_cnt;
      push(1'b0, 1'b1, 16'h1234, 8'h00);
      @(negedge core_clk);
      req_valid = 1'b0;
      repeat (40) @(negedge core_clk);
      `CHK("on-chip answer", c, rd_cnt)
      `CHK("on-chip stall", 1'b0, cpu_stall)
    end
  endtask : t_onchip

  task automatic t_upper();
    port_upper_sel     = 1'b1;
    ext_mem_config_reg = 8'h14;
    ext_mem_timing_reg = 8'h05;
    mv(1'b1, 1'b1, 16'hABCD, 8'h3C);
    mv(1'b0, 1'b1, 16'hABCD, 8'h3C);
    port_upper_sel = 1'b0;
  endtask : t_upper

  task automatic t_fifo();
    int k;
    ext_mem_config_reg = 8'h1C;
    ext_mem_timing_reg = 8'hFF;
    full_seen = 1'b0;
    for (int i = 0; i < 10; i++) push(1'b1, 1'b0, 16'(i), 8'(8'hA0 + i));
    @(negedge core_clk);
    req_valid = 1'b0;
    k = 0;
    while (cpu_stall !== 1'b0 && k < 600) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 600) bad_count++;
    `CHK("buffer refused", 1'b1, full_seen)
    mv(1'b0, 1'b1, 16'hFF00, 8'hA0);
    mv(1'b0, 1'b1, 16'hFF09, 8'hA9);
  endtask : t_fifo

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst_n = 1'b0;
    port_upper_sel = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_wide = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    ext_mem_config_reg = CFG_RESET;
    ext_mem_timing_reg = TIM_RESET;
    ext_mem_bank_reg = 8'h5A;
    full_seen = 1'b0;
    bad_count = 0;
    compares = 0;
    rd_cnt = 0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK("idle read strobe", 1'b1, lo_rd_n)
    `CHK("idle data enable", 8'h00, lo_data_oe)
    t_modes();
    t_onchip();
    t_upper();
    t_fifo();
    wrap_up();
  end

  // whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end
endmodule : testbench
